/* File: hw/aldp_core.sv */
// add, mask and shift datapath with two indirect pointer pairs
// assumes decoder and data memory on clk_sys; apb master on clk_sys
// What this block does
// (RQ1) pointer add: signed -32..31 added to chosen pointer pair, flags untouched
// (RQ2) pointer sums wrap within sixteen bits, never saturate
// (RQ3) immediate add: acc plus 8-bit immediate into acc, sets carry, spill, zero
// (RQ4) register add: acc plus register 0..127, sets carry, spill, zero
// (RQ5) destination bit 0 writes acc, 1 writes the addressed register
// (RQ6) add with carry: acc plus register plus carry, sets carry, spill, zero
// (RQ7) register mask: acc AND register, only Z changes
// (RQ8) immediate mask: acc AND immediate into acc, only Z changes
// (RQ9) shift right keeps bit 7, bit 0 goes to carry, sets C, Z
// (RQ10) indirect access through pointer with top bit set costs one more cycle
// (RQ11) branch or true test costs two cycles, second one idles
// (RQ12) Z on zero result, C from bit 7, spill from bit 3
// (RQ13) unlisted flags hold; flags change with the result write
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module aldp_core
    import aldp_pkg::*;
(
    input  logic                    clk_sys,
    input  logic                    rst_b,
    input  logic                    ce,
    input  logic                    psel,
    input  logic                    penable,
    input  logic                    pwrite,
    input  logic [PADDR_W-1:0]      paddr,
    input  logic [31:0]             pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  logic                    issue_valid,
    input  aldp_op_e                issue_op,
    input  logic [DATA_W-1:0]       issue_imm,
    input  logic [REG_ADDR_W-1:0]   issue_addr,
    input  logic                    issue_dest,
    input  logic                    issue_ptr_sel,
    input  logic                    issue_indirect,
    input  logic                    issue_two_cycle,
    input  logic [DATA_W-1:0]       mem_rdata,
    output logic                    issue_ready,
    output logic                    nop_slot,
    output logic                    mem_we,
    output logic [REG_ADDR_W-1:0]   mem_waddr,
    output logic [DATA_W-1:0]       mem_wdata,
    output logic [DATA_W-1:0]       acc,
    output logic [FLAG_W-1:0]       flags,
    output logic [PTR_W-1:0]        ptr_pair_0,
    output logic [PTR_W-1:0]        ptr_pair_1
);

    typedef enum logic [1:0] {st_exec, st_extra, st_nop} aldp_state_e;

    // =====================================================================
    // state
    aldp_state_e            state_r, state_nxt;
    logic [DATA_W-1:0]      acc_r, acc_nxt;
    logic [FLAG_W-1:0]      flags_r, flags_nxt;
    logic [PTR_W-1:0]       ptr_r [PTR_NUM];
    logic                   ctrl_en_r;
    logic                   pend_nop_r;
    logic                   ready_r;
    logic                   nop_r;
    logic                   we_r;
    logic [REG_ADDR_W-1:0]  waddr_r;
    logic [DATA_W-1:0]      wdata_r;
    logic [CNT_W-1:0]       count_r;
    logic [31:0]            prdata_r;
    logic                   pready_r;
    logic                   pslverr_r;

    // =====================================================================
    // apb decode
    function automatic logic [2:0] reg_index(input logic [PADDR_W-1:0] a);
        case (a)
            ADDR_ACC:   reg_index = 3'h1;
            ADDR_FLAGS: reg_index = 3'h2;
            ADDR_PTR0:  reg_index = 3'h3;
            ADDR_PTR1:  reg_index = 3'h4;
            ADDR_CTRL:  reg_index = 3'h5;
            ADDR_STATE: reg_index = 3'h6;
            ADDR_COUNT: reg_index = 3'h7;
            default:    reg_index = 3'h0;
        endcase
    endfunction

    wire        apb_setup = psel && !penable;
    wire [2:0]  apb_idx   = reg_index(paddr);
    wire        apb_wr    = psel && penable && pready_r && pwrite && !pslverr_r;
    wire        wr_acc    = apb_wr && (apb_idx == 3'h1);
    wire        wr_flags  = apb_wr && (apb_idx == 3'h2);
    wire        wr_ptr0   = apb_wr && (apb_idx == 3'h3);
    wire        wr_ptr1   = apb_wr && (apb_idx == 3'h4);
    wire        wr_ctrl   = apb_wr && (apb_idx == 3'h5);
    wire [31:0] rd_mux    =
        (apb_idx == 3'h1) ? {24'h000000, acc_r} :
        (apb_idx == 3'h2) ? {29'h00000000, flags_r} :
        (apb_idx == 3'h3) ? {16'h0000, ptr_r[0]} :
        (apb_idx == 3'h4) ? {16'h0000, ptr_r[1]} :
        (apb_idx == 3'h5) ? {31'h00000000, ctrl_en_r} :
        (apb_idx == 3'h6) ? {28'h0000000, ready_r, nop_r, state_r} :
        (apb_idx == 3'h7) ? {16'h0000, count_r} : 32'h00000000;

    // =====================================================================
    // operand selection and arithmetic
    wire take      = issue_valid && ready_r;
    wire is_ptr    = (issue_op == op_pointer_offset_add);
    wire is_addc   = (issue_op == op_acc_plus_reg_with_carry);
    wire is_add    = (issue_op == op_immediate_sum_to_acc) || (issue_op == op_acc_plus_reg)
                     || is_addc;
    wire is_and    = (issue_op == op_acc_mask_reg) || (issue_op == op_acc_mask_immediate);
    wire is_shift  = (issue_op == op_signed_shift_right_reg);
    wire is_imm    = (issue_op == op_immediate_sum_to_acc)
                     || (issue_op == op_acc_mask_immediate);
    wire is_alu    = is_add || is_and || is_shift;
    wire to_reg    = is_alu && !is_imm && issue_dest;                           // RQ5
    wire to_acc    = is_alu && !to_reg;                                         // RQ5

    wire [DATA_W-1:0] src_b  = is_imm ? issue_imm : mem_rdata;
    wire              cin    = is_addc & flags_r[FLAG_C];                      // RQ6
    wire [8:0]        sum9   = {1'b0, acc_r} + {1'b0, src_b} + {8'h00, cin};    // RQ3 RQ4
    wire [4:0]        sum5   = {1'b0, acc_r[3:0]} + {1'b0, src_b[3:0]} + {4'h0, cin};
    wire [DATA_W-1:0] and8   = acc_r & src_b;                                   // RQ7 RQ8
    wire [DATA_W-1:0] asr8   = {mem_rdata[7], mem_rdata[7:1]};                  // RQ9
    wire [DATA_W-1:0] result = is_add ? sum9[7:0] : is_and ? and8 : asr8;

    // sign extension done here so a -32 offset wraps rather than saturates
    wire [PTR_W-1:0]  ptr_off = {{(PTR_W-PTR_IMM_W){issue_imm[PTR_IMM_W-1]}},
                                 issue_imm[PTR_IMM_W-1:0]};                     // RQ1
    wire [PTR_W-1:0]  ptr_sum = ptr_r[issue_ptr_sel] + ptr_off;                 // RQ2
    wire              hi_ptr  = issue_indirect && ptr_r[issue_ptr_sel][PTR_W-1]; // RQ10

    // =====================================================================
    // flag and accumulator next values
    always_comb begin
        flags_nxt = flags_r;
        acc_nxt   = acc_r;
        if (take && is_alu) begin
            if (is_add || is_shift) begin
                flags_nxt[FLAG_C] = is_add ? sum9[8] : mem_rdata[0];           // RQ9 RQ12
            end
            if (is_add) begin
                flags_nxt[FLAG_SPILL] = sum5[4];                               // RQ12
            end
            flags_nxt[FLAG_Z] = (result == 8'h00);                            // RQ12 RQ13
            if (to_acc) begin
                acc_nxt = result;
            end
        end else if (!take) begin
            // core traffic wins; software edits only land in idle cycles
            if (wr_flags) begin
                flags_nxt = pwdata[FLAG_W-1:0];
            end
            if (wr_acc) begin
                acc_nxt = pwdata[DATA_W-1:0];
            end
        end
    end

    // =====================================================================
    // cycle stretching
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_exec: begin
                if (take && hi_ptr) begin
                    state_nxt = st_extra;                                     // RQ10
                end else if (take && issue_two_cycle) begin
                    state_nxt = st_nop;                                       // RQ11
                end
            end
            st_extra: begin
                state_nxt = pend_nop_r ? st_nop : st_exec;
            end
            st_nop: begin
                state_nxt = st_exec;
            end
            default: begin
                state_nxt = st_exec;
            end
        endcase
    end

    // =====================================================================
    // registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= st_exec;
            acc_r      <= ACC_RST;
            flags_r    <= FLAGS_RST;
            pend_nop_r <= 1'b0;
            ready_r    <= 1'b0;
            nop_r      <= 1'b0;
        end else if (ce) begin
            state_r    <= state_nxt;
            acc_r      <= acc_nxt;
            flags_r    <= flags_nxt;
            pend_nop_r <= take ? issue_two_cycle : pend_nop_r;
            ready_r    <= (state_nxt == st_exec) && ctrl_en_r;
            nop_r      <= (state_nxt == st_nop);                               // RQ11
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            we_r    <= 1'b0;
            waddr_r <= '0;
            wdata_r <= 8'h00;
            count_r <= CNT_RST;
        end else if (ce) begin
            we_r    <= take && to_reg;                                         // RQ5
            waddr_r <= take ? issue_addr : waddr_r;
            wdata_r <= take ? result : wdata_r;
            count_r <= take ? count_r + 16'h0001 : count_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PTR_NUM; gi++) begin : g_ptr
            wire hit_core = take && is_ptr && (issue_ptr_sel == 1'(gi));
            wire hit_apb  = !take && ((gi == 0) ? wr_ptr0 : wr_ptr1);
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    ptr_r[gi] <= PTR_RST;
                end else if (ce && hit_core) begin
                    ptr_r[gi] <= ptr_sum;                                      // RQ1 RQ2
                end else if (ce && hit_apb) begin
                    ptr_r[gi] <= pwdata[PTR_W-1:0];
                end
            end
        end
    endgenerate

    // zero-wait slave: answer is prepared in the setup cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_en_r <= CTRL_RST;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            ctrl_en_r <= wr_ctrl ? pwdata[CTRL_EN] : ctrl_en_r;
            prdata_r  <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup && (apb_idx == 3'h0);
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign issue_ready = ready_r;
    assign nop_slot    = nop_r;
    assign mem_we      = we_r;
    assign mem_waddr   = waddr_r;
    assign mem_wdata   = wdata_r;
    assign acc         = acc_r;
    assign flags       = flags_r;
    assign ptr_pair_0  = ptr_r[0];
    assign ptr_pair_1  = ptr_r[1];

    // =====================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    wire [8:0] ref_sum = {1'b0, acc_r} + {1'b0, mem_rdata};
    wire [8:0] ref_sumc = {1'b0, acc_r} + {1'b0, mem_rdata} + {8'h00, flags_r[FLAG_C]};

    sequence seq_ptr_take;
        ce && take && is_ptr;
    endsequence
    sequence seq_hi_take;
        ce && take && hi_ptr;
    endsequence

    chk_ptr_wrap_sum: assert property (seq_ptr_take |=>                        // RQ1
        ptr_r[$past(issue_ptr_sel)] == $past(ptr_r[issue_ptr_sel])
            + {{10{$past(issue_imm[5])}}, $past(issue_imm[5:0])}
        && flags_r == $past(flags_r)) else $error("pointer add wrong");
    chk_ptr_rollover: assert property (seq_ptr_take and                        // RQ2
        (ptr_r[issue_ptr_sel] == 16'hffff && issue_imm[5:0] == 6'h01)
        |=> ptr_r[$past(issue_ptr_sel)] == 16'h0000) else $error("pointer no wrap");
    chk_imm_add_acc: assert property (ce && take                               // RQ3
        && issue_op == op_immediate_sum_to_acc |=>
        acc_r == 8'($past(acc_r) + $past(issue_imm))) else $error("immediate add wrong");
    chk_reg_add_flags: assert property (ce && take                             // RQ4
        && issue_op == op_acc_plus_reg |=> flags_r[FLAG_C] == $past(ref_sum[8])
        && flags_r[FLAG_Z] == ($past(ref_sum[7:0]) == 8'h00)) else $error("add flags wrong");
    chk_dest_route: assert property (ce && take && is_alu && !is_imm           // RQ5
        && issue_dest |=> mem_we && mem_waddr == $past(issue_addr)
        && acc_r == $past(acc_r) ##1 (!mem_we || !$past(ce))) else $error("dest route wrong");
    chk_addc_sum: assert property (ce && take && is_addc && !issue_dest |=>    // RQ6
        acc_r == $past(ref_sumc[7:0]) && flags_r[FLAG_C] == $past(ref_sumc[8]))
        else $error("carry add wrong");
    chk_mask_zero: assert property (ce && take && is_and |=>                   // RQ7
        flags_r[FLAG_C] == $past(flags_r[FLAG_C])
        && flags_r[FLAG_SPILL] == $past(flags_r[FLAG_SPILL])
        && flags_r[FLAG_Z] == ($past(and8) == 8'h00)) else $error("mask flags wrong");
    chk_mask_imm_acc: assert property (ce && take                              // RQ8
        && issue_op == op_acc_mask_immediate |=>
        acc_r == ($past(acc_r) & $past(issue_imm))) else $error("immediate mask wrong");
    chk_shift_carry: assert property (ce && take && is_shift && issue_dest |=> // RQ9
        mem_wdata[7:6] == {2{$past(mem_rdata[7])}}
        && flags_r[FLAG_C] == $past(mem_rdata[0])
        && flags_r[FLAG_SPILL] == $past(flags_r[FLAG_SPILL])) else $error("shift wrong");
    chk_extra_cycle: assert property (seq_hi_take |=> !issue_ready             // RQ10
        && state_r == st_extra) else $error("no extra cycle");
    chk_nop_slot: assert property (ce && take && !hi_ptr && issue_two_cycle    // RQ11
        |=> nop_slot && !issue_ready) else $error("no idle slot");
    chk_flag_hold: assert property (ce && !take && !wr_flags                   // RQ13
        |=> flags_r == $past(flags_r)) else $error("flags moved");

endmodule

/* File: hw/aldp_pkg.sv */
// package for the add / mask / shift datapath of the core
// assumes a 32-bit apb master and a decoder on the same clock
package aldp_pkg;

    // =====================================================================
    // operations presented by the decoder
    typedef enum logic [2:0] {
        op_none,
        op_pointer_offset_add,
        op_immediate_sum_to_acc,
        op_acc_plus_reg,
        op_acc_plus_reg_with_carry,
        op_acc_mask_reg,
        op_acc_mask_immediate,
        op_signed_shift_right_reg
    } aldp_op_e;

    // =====================================================================
    // widths and field positions
    localparam int DATA_W     = 8;
    localparam int PTR_W      = 16;
    localparam int PTR_IMM_W  = 6;
    localparam int REG_ADDR_W = 7;
    localparam int PTR_NUM    = 2;
    localparam int FLAG_W     = 3;
    localparam int FLAG_C     = 0;
    localparam int FLAG_SPILL = 1;
    localparam int FLAG_Z     = 2;
    localparam int PADDR_W    = 12;
    localparam int CNT_W      = 16;
    localparam int CTRL_EN    = 0;

    // =====================================================================
    // register map, byte addresses
    localparam logic [PADDR_W-1:0] ADDR_ACC   = 12'h000;
    localparam logic [PADDR_W-1:0] ADDR_FLAGS = 12'h004;
    localparam logic [PADDR_W-1:0] ADDR_PTR0  = 12'h008;
    localparam logic [PADDR_W-1:0] ADDR_PTR1  = 12'h00c;
    localparam logic [PADDR_W-1:0] ADDR_CTRL  = 12'h010;
    localparam logic [PADDR_W-1:0] ADDR_STATE = 12'h014;
    localparam logic [PADDR_W-1:0] ADDR_COUNT = 12'h018;

    // =====================================================================
    // reset values
    localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;
    localparam logic [PTR_W-1:0]  PTR_RST   = 16'h0000;
    localparam logic              CTRL_RST  = 1'b1;
    localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;

endpackage

/* File: testbench/aldp_mem_model.sv */
// data memory seen by the datapath: 128 bytes, combinational read port
// assumes writes arrive as a one-cycle strobe on clk_sys
`timescale 1ns/1ns
module aldp_mem_model
    import aldp_pkg::*;
(
    input  logic                  clk_sys,
    input  logic                  valid,
    input  logic [REG_ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0]     rdata,
    input  logic                  we,
    input  logic [REG_ADDR_W-1:0] waddr,
    input  logic [DATA_W-1:0]     wdata
);
    // =====================================================================
    // storage
    logic [DATA_W-1:0] mem [128];

    initial begin
        foreach (mem[i]) mem[i] = '0;
    end

    // no issue pending: show inverted data so a stray sample cannot pass
    assign rdata = valid ? mem[raddr] : ~mem[raddr];

    always @(posedge clk_sys) begin
        if (we === 1'b1) begin
            mem[waddr] <= wdata;
        end
    end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the add / mask / shift datapath
// assumes aldp_core and aldp_mem_model are compiled before it
`timescale 1ns/1ns
module tb_top
    import aldp_pkg::*;
;
    // =====================================================================
    // signals
    logic                  clk_sys, rst_b, ce, psel, penable, pwrite, pready, pslverr;
    logic [PADDR_W-1:0]    paddr;
    logic [31:0]           pwdata, prdata, rv;
    logic                  ev, issue_valid, issue_dest, issue_ptr_sel;
    logic                  issue_indirect, issue_two_cycle, issue_ready, nop_slot, mem_we;
    aldp_op_e              issue_op;
    logic [DATA_W-1:0]     issue_imm, mem_rdata, mem_wdata, acc;
    logic [REG_ADDR_W-1:0] issue_addr, mem_waddr;
    logic [FLAG_W-1:0]     flags;
    logic [PTR_W-1:0]      ptr_pair_0, ptr_pair_1;
    int                    fail_count, n_checks, cyc, nops, n_iss, t_take;

    aldp_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .issue_valid(issue_valid),
        .issue_op(issue_op), .issue_imm(issue_imm), .issue_addr(issue_addr),
        .issue_dest(issue_dest), .issue_ptr_sel(issue_ptr_sel),
        .issue_indirect(issue_indirect), .issue_two_cycle(issue_two_cycle),
        .mem_rdata(mem_rdata), .issue_ready(issue_ready), .nop_slot(nop_slot),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .acc(acc),
        .flags(flags), .ptr_pair_0(ptr_pair_0), .ptr_pair_1(ptr_pair_1));

    aldp_mem_model mdl (.clk_sys(clk_sys), .valid(issue_valid), .raddr(issue_addr),
        .rdata(mem_rdata), .we(mem_we), .waddr(mem_waddr), .wdata(mem_wdata));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // cycle stamp for issue spacing; also cuts a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (nop_slot === 1'b1) nops <= nops + 1;
        if (cyc == 4000) begin
            fail_count++;
            print_verdict();
        end
    end

    // =====================================================================
    // tasks
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: the next setup never reassigns psel in this time step
        @(posedge clk_sys);
    endtask

    task rchk(input logic [PADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rv, ev);
        chk($sformatf("read %h", a), rv, exp);
    endtask

    task iss(input aldp_op_e op, input logic [7:0] imm, input logic [6:0] a,
             input logic d, input logic s, input logic ind, input logic two);
        issue_valid <= 1'b1;
        issue_op <= op;
        issue_imm <= imm;
        issue_addr <= a;
        issue_dest <= d;
        issue_ptr_sel <= s;
        issue_indirect <= ind;
        issue_two_cycle <= two;
        do begin
            @(posedge clk_sys);
        end while (issue_ready !== 1'b1);
        t_take = cyc;
        n_iss++;
    endtask

    task settle;
        issue_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task run(input aldp_op_e op, input logic [7:0] imm, input logic [6:0] a,
             input logic d, input logic s, input logic [7:0] ea, input logic [2:0] ef);
        iss(op, imm, a, d, s, 1'b0, 1'b0);
        settle();
        chk("acc", {24'h0, acc}, {24'h0, ea});
        chk("flags", {29'h0, flags}, {29'h0, ef});
    endtask

    // first op may stretch; the follow-up shows when issue reopens
    task gap(input logic s, input logic ind, input logic two, input int eg);
        int t1, n0;
        n0 = nops;
        iss(op_acc_mask_immediate, 8'hff, 7'h00, 1'b0, s, ind, two);
        t1 = t_take;
        iss(op_acc_mask_immediate, 8'hff, 7'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("issue gap", t_take - t1, eg);
        settle();
        chk("idle slots", nops - n0, {31'h0, two});
    endtask

    // =====================================================================
    // sequence
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, issue_valid} = '0;
        {issue_imm, issue_addr, issue_dest, issue_ptr_sel} = '0;
        {issue_indirect, issue_two_cycle, fail_count, n_checks, cyc, nops, n_iss} = '0;
        issue_op = op_none;
        ce = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rchk(ADDR_ACC, 32'h0);
        rchk(ADDR_CTRL, 32'h1);
        apb(1'b0, 12'h01c, 32'h0, rv, ev);
        chk("unmapped error", {31'h0, ev}, 32'h1);
        mdl.mem[127] = 8'h7f;
        mdl.mem[5] = 8'h0f;
        mdl.mem[9] = 8'h81;
        mdl.mem[3] = 8'h01;
        apb(1'b1, ADDR_ACC, 32'hf8, rv, ev);
        run(op_immediate_sum_to_acc, 8'h08, 7'h00, 1'b0, 1'b0, 8'h00, 3'b111);
        run(op_acc_plus_reg, 8'h00, 7'h7f, 1'b0, 1'b0, 8'h7f, 3'b000);
        run(op_acc_plus_reg, 8'h00, 7'h7f, 1'b1, 1'b0, 8'h7f, 3'b010);
        chk("reg 127", {24'h0, mdl.mem[127]}, 32'hfe);
        run(op_immediate_sum_to_acc, 8'h81, 7'h00, 1'b0, 1'b0, 8'h00, 3'b111);
        run(op_acc_plus_reg_with_carry, 8'h00, 7'h05, 1'b0, 1'b0, 8'h10, 3'b010);
        run(op_acc_mask_reg, 8'h00, 7'h05, 1'b1, 1'b0, 8'h10, 3'b110);
        chk("reg 5", {24'h0, mdl.mem[5]}, 32'h0);
        run(op_acc_mask_immediate, 8'h30, 7'h00, 1'b0, 1'b0, 8'h10, 3'b010);
        run(op_signed_shift_right_reg, 8'h00, 7'h09, 1'b0, 1'b0, 8'hc0, 3'b011);
        run(op_signed_shift_right_reg, 8'h00, 7'h03, 1'b1, 1'b0, 8'hc0, 3'b111);
        chk("reg 3", {24'h0, mdl.mem[3]}, 32'h0);
        apb(1'b1, ADDR_PTR0, 32'hffff, rv, ev);
        run(op_pointer_offset_add, 8'h01, 7'h00, 1'b0, 1'b0, 8'hc0, 3'b111);
        chk("pointer 0", {16'h0, ptr_pair_0}, 32'h0);
        run(op_pointer_offset_add, 8'hdf, 7'h00, 1'b0, 1'b0, 8'hc0, 3'b111);
        chk("pointer 0", {16'h0, ptr_pair_0}, 32'h1f);
        run(op_pointer_offset_add, 8'h20, 7'h00, 1'b0, 1'b1, 8'hc0, 3'b111);
        chk("pointer 1", {16'h0, ptr_pair_1}, 32'hffe0);
        rchk(ADDR_PTR1, 32'hffe0);
        gap(1'b0, 1'b1, 1'b0, 1);
        gap(1'b1, 1'b1, 1'b0, 2);
        gap(1'b0, 1'b0, 1'b1, 2);
        gap(1'b1, 1'b1, 1'b1, 3);
        rchk(ADDR_FLAGS, 32'h3);
        rchk(ADDR_COUNT, n_iss);
        print_verdict();
    end
endmodule
